// ### core/prc_params.svh
// constants for the regulator control register bank
// assumes inclusion by prc_pkg and the design modules only
`ifndef PRC_PARAMS_SVH
`define PRC_PARAMS_SVH

// ==========================================================
// register offsets
`define PRC_OFS_SYS_CTRL 8'h07
`define PRC_OFS_REG_EN 8'h10
`define PRC_OFS_REG_STAT 8'h11
`define PRC_OFS_VCHG 8'h20
`define PRC_OFS_B1_TGT_A 8'h23

// ==========================================================
// field positions
`define PRC_SC_DLY_HI 6
`define PRC_SC_DLY_LO 4
`define PRC_SC_RSV3 3
`define PRC_SC_BUCK2_FORCE_FIXED_MODE 2
`define PRC_SC_BUCK1_FORCE_FIXED_MODE 1
`define PRC_EN_LIN2 6
`define PRC_EN_RSV5 5
`define PRC_EN_LIN1 4
`define PRC_EN_BK2 2
`define PRC_EN_BK1 0
`define PRC_ST_ALLBK 7
`define PRC_ST_ALLLIN 6
`define PRC_ST_LIN2 5
`define PRC_ST_LIN1 4
`define PRC_ST_BK2 2
`define PRC_ST_BK1 0
`define PRC_VC_SEL2 5
`define PRC_VC_GO2 4
`define PRC_VC_SEL1 1
`define PRC_VC_GO1 0
`define PRC_TGT_HI 4

// ==========================================================
// reset values
`define PRC_DLY_RESET 3'h2
`define PRC_EN_RESET 4'hF
`define PRC_RSV3_RESET 1'h1
`define PRC_RSV5_RESET 1'h1

// ==========================================================
// buck1 code decode
`define PRC_B1_BASE_MV 12'h320
`define PRC_B1_STEP_MV 12'h032
`define PRC_B1_MAX_CODE 5'h19

// ==========================================================
// timing and serial device address
`define PRC_CLK_PERIOD_NS 10
`define PRC_DLY_UNIT_NS 500000
`define PRC_RAMP_STEP_NS 6250
`define PRC_DLY_UNIT_CYC (`PRC_DLY_UNIT_NS / `PRC_CLK_PERIOD_NS)
`define PRC_RAMP_STEP_CYC (`PRC_RAMP_STEP_NS / `PRC_CLK_PERIOD_NS)
`define PRC_I2C_ADDR 7'h60

`endif

// ### core/prc_pkg.sv
// types of the regulator control register bank
// assumes prc_params.svh is reachable on the include path
`include "prc_params.svh"

package prc_pkg;

  // ==========================================================
  // serial slave states
  typedef enum logic [3:0] {
    PRC_IDLE      = 4'h0,
    PRC_ADDR      = 4'h1,
    PRC_ADDR_ACK  = 4'h3,
    PRC_REG       = 4'h2,
    PRC_REG_ACK   = 4'h6,
    PRC_WDATA     = 4'h7,
    PRC_WDATA_ACK = 4'h5,
    PRC_RDATA     = 4'h4,
    PRC_RDATA_ACK = 4'hC
  } prc_i2c_e;

  // ==========================================================
  // per-regulator bundle: buck1, buck2, linreg1, linreg2
  typedef struct packed {
    logic linreg2;
    logic linreg1;
    logic buck2;
    logic buck1;
  } prc_regs4_s;

  // ==========================================================
  // serial pins
  typedef struct packed {
    logic scl;
    logic sda;
  } prc_pins_s;

endpackage

// ### core/prc_power_seq.sv
// power-on delay sequencer: staggers regulator turn-on after the enable pin
// assumes a 100 MHz clock and an enable pin synchronous to it
`include "prc_params.svh"

module prc_power_seq
  import prc_pkg::*;
#(
  parameter int UNIT_CYCLES = `PRC_DLY_UNIT_CYC
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // control
  input wire logic en_pin_in,
  input wire logic [2:0] delay_code_in,
  input prc_regs4_s reg_on_in,
  // regulator drive
  output prc_regs4_s reg_drive_out
);

  typedef struct packed {
    logic [31:0] div;
    logic [4:0] units;
    prc_regs4_s drive;
  } prc_seq_s;

  prc_seq_s s_q, s_d;

  // delay in half-millisecond units for one regulator
  function automatic logic [4:0] dly_units(input logic [2:0] code, input logic [1:0] idx);
    logic [19:0] row;
    row = 20'h0;
    case (code)
      3'h0: row = {5'h02, 5'h02, 5'h02, 5'h02};
      3'h1: row = {5'h04, 5'h04, 5'h03, 5'h02};
      3'h2: row = {5'h0C, 5'h06, 5'h04, 5'h03};
      3'h3: row = {5'h02, 5'h02, 5'h04, 5'h03};
      3'h4: row = {5'h0C, 5'h06, 5'h04, 5'h03};
      3'h5: row = {5'h04, 5'h04, 5'h03, 5'h03};
      3'h6: row = {5'h03, 5'h02, 5'h04, 5'h06};
      default: row = {5'h16, 5'h0C, 5'h06, 5'h04};
    endcase
    return row[idx*5 +: 5];
  endfunction

  always_comb begin
    s_d = s_q;
    if (!en_pin_in) begin
      s_d.div = 32'h0;
      s_d.units = 5'h00;
    end else if (s_q.div == 32'(UNIT_CYCLES - 1)) begin
      s_d.div = 32'h0;
      if (s_q.units != 5'h1F) begin
        s_d.units = s_q.units + 5'h01;
      end
    end else begin
      s_d.div = s_q.div + 32'h1;
    end
    // each regulator starts once its preset delay has elapsed
    s_d.drive.buck1 = reg_on_in.buck1 & en_pin_in & (s_q.units >= dly_units(delay_code_in, 2'h0));
    s_d.drive.buck2 = reg_on_in.buck2 & en_pin_in & (s_q.units >= dly_units(delay_code_in, 2'h1));
    s_d.drive.linreg1 = reg_on_in.linreg1 & en_pin_in
                        & (s_q.units >= dly_units(delay_code_in, 2'h2));
    s_d.drive.linreg2 = reg_on_in.linreg2 & en_pin_in
                        & (s_q.units >= dly_units(delay_code_in, 2'h3));
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_drive_out = s_q.drive;

endmodule

// ### core/prc_regulator_control_regs.sv
// control and status register bank of a two-buck, two-linreg power unit
// assumes scl/sda pins are sampled synchronously to ref_clk_in
// Notes on behaviour
// - three-bit delay code picks one of eight start delay sets after enable pin; codes 2 and 4 give the same set.
// - per-buck mode bit: zero auto PFM/PWM, one forces PWM only.
// - enable register holds one read-write on bit per regulator.
// - read-only status shows per-regulator and aggregate valid flags, reset zero.
// - per-buck select bit chooses target register one or two.
// - ramp bit zero holds output; one ramps toward the selected target.
// - buck1 code zero is external control; 1..25 is 0.80-2.00 V, above saturates.
// - delay code resets to 010.
// - registers reached through a serial slave timed by the master's clock line.
`include "prc_params.svh"

module prc_regulator_control_regs
  import prc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `PRC_I2C_ADDR,
  parameter int UNIT_CYCLES = `PRC_DLY_UNIT_CYC,
  parameter int RAMP_CYCLES = `PRC_RAMP_STEP_CYC,
  parameter logic BUCK1_FORCE_FIXED_MODE_DEFAULT = 1'b0,
  parameter logic BUCK2_FORCE_FIXED_MODE_DEFAULT = 1'b0,
  parameter logic [4:0] B1_TGT_DEFAULT = 5'h09
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // serial bus
  input prc_pins_s pins_in,
  output logic sda_out,
  output logic sda_oe_out,
  // power controls
  input wire logic en_pin_in,
  input prc_regs4_s valid_in,
  input wire logic [4:0] buck1_target_b_in,
  // regulator controls
  output prc_regs4_s reg_drive_out,
  output logic buck1_force_fixed_mode_out,
  output logic buck2_force_fixed_mode_out,
  output logic buck2_target_select_out,
  output logic buck2_ramp_go_out,
  output logic [4:0] buck1_voltage_code_out,
  output logic buck1_ext_ctrl_out,
  output logic [11:0] buck1_mv_out
);

  typedef struct packed {
    prc_i2c_e st;
    prc_pins_s pins;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rd;
    logic nack;
    logic oe;
    logic [2:0] power_on_delay_code;
    logic buck2_force_fixed_mode;
    logic buck1_force_fixed_mode;
    prc_regs4_s on;
    logic buck2_target_select;
    logic buck2_ramp_go;
    logic buck1_target_select;
    logic buck1_ramp_go;
    logic [4:0] buck1_target_a;
    logic [4:0] b1_code;
    logic [31:0] ramp_div;
    logic [7:0] status;
    logic [11:0] b1_mv;
  } prc_state_s;

  prc_state_s s_q, s_d;

  // ==========================================================
  // register read mux, reserved bits at reset value
  function automatic logic [7:0] read_reg(input prc_state_s s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `PRC_OFS_SYS_CTRL: begin
        v[`PRC_SC_DLY_HI:`PRC_SC_DLY_LO] = s.power_on_delay_code;
        v[`PRC_SC_RSV3] = `PRC_RSV3_RESET;
        v[`PRC_SC_BUCK2_FORCE_FIXED_MODE] = s.buck2_force_fixed_mode;
        v[`PRC_SC_BUCK1_FORCE_FIXED_MODE] = s.buck1_force_fixed_mode;
      end
      `PRC_OFS_REG_EN: begin
        v[`PRC_EN_LIN2] = s.on.linreg2;
        v[`PRC_EN_RSV5] = `PRC_RSV5_RESET;
        v[`PRC_EN_LIN1] = s.on.linreg1;
        v[`PRC_EN_BK2] = s.on.buck2;
        v[`PRC_EN_BK1] = s.on.buck1;
      end
      `PRC_OFS_REG_STAT: v = s.status;
      `PRC_OFS_VCHG: begin
        v[`PRC_VC_SEL2] = s.buck2_target_select;
        v[`PRC_VC_GO2] = s.buck2_ramp_go;
        v[`PRC_VC_SEL1] = s.buck1_target_select;
        v[`PRC_VC_GO1] = s.buck1_ramp_go;
      end
      `PRC_OFS_B1_TGT_A: v[`PRC_TGT_HI:0] = s.buck1_target_a;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // buck1 code to millivolts, zero for external control
  function automatic logic [11:0] b1_code_mv(input logic [4:0] c);
    logic [4:0] k;
    k = (c > `PRC_B1_MAX_CODE) ? `PRC_B1_MAX_CODE : c;
    if (c == 5'h00) begin
      return 12'h000;
    end
    return `PRC_B1_BASE_MV + 12'(`PRC_B1_STEP_MV * 12'(k - 5'h01));
  endfunction

  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic [4:0] b1_goal;

  // data bits are paced by the master's clock line; start and stop by sda edges while scl is high
  assign scl_rise = pins_in.scl & ~s_q.pins.scl;
  assign scl_fall = ~pins_in.scl & s_q.pins.scl;
  assign start_seen = pins_in.scl & s_q.pins.scl & s_q.pins.sda & ~pins_in.sda;
  assign stop_seen = pins_in.scl & s_q.pins.scl & ~s_q.pins.sda & pins_in.sda;
  assign b1_goal = s_q.buck1_target_select ? buck1_target_b_in : s_q.buck1_target_a;

  always_comb begin
    s_d = s_q;
    s_d.pins = pins_in;
    // ==========================================================
    // serial slave
    if (start_seen) begin
      s_d.st = PRC_ADDR;
      s_d.bits = 4'h0;
      s_d.oe = 1'b0;
    end else if (stop_seen) begin
      s_d.st = PRC_IDLE;
      s_d.oe = 1'b0;
    end else if (scl_rise) begin
      case (s_q.st)
        PRC_ADDR, PRC_REG, PRC_WDATA: begin
          s_d.sh = {s_q.sh[6:0], pins_in.sda};
          s_d.bits = s_q.bits + 4'h1;
        end
        PRC_RDATA: s_d.bits = s_q.bits + 4'h1;
        PRC_RDATA_ACK: s_d.nack = pins_in.sda;
        default: s_d.st = s_q.st;
      endcase
    end else if (scl_fall) begin
      case (s_q.st)
        PRC_ADDR: begin
          if (s_q.bits == 4'h8) begin
            if (s_q.sh[7:1] == DEV_ADDR) begin
              s_d.st = PRC_ADDR_ACK;
              s_d.rd = s_q.sh[0];
              s_d.oe = 1'b1;
            end else begin
              s_d.st = PRC_IDLE;
            end
          end
        end
        PRC_ADDR_ACK: begin
          s_d.bits = 4'h0;
          if (s_q.rd) begin
            // read uses the pointer left by the preceding write
            s_d.sh = read_reg(s_q, s_q.ptr);
            s_d.oe = ~s_d.sh[7];
            s_d.st = PRC_RDATA;
          end else begin
            s_d.oe = 1'b0;
            s_d.st = PRC_REG;
          end
        end
        PRC_REG: begin
          if (s_q.bits == 4'h8) begin
            s_d.ptr = s_q.sh;
            s_d.oe = 1'b1;
            s_d.st = PRC_REG_ACK;
          end
        end
        PRC_REG_ACK, PRC_WDATA_ACK: begin
          s_d.oe = 1'b0;
          s_d.bits = 4'h0;
          s_d.st = PRC_WDATA;
        end
        PRC_WDATA: begin
          if (s_q.bits == 4'h8) begin
            s_d.oe = 1'b1;
            s_d.st = PRC_WDATA_ACK;
            s_d.ptr = s_q.ptr + 8'h01;
            // reserved and read-only bits are not stored
            case (s_q.ptr)
              `PRC_OFS_SYS_CTRL: begin
                s_d.power_on_delay_code = s_q.sh[`PRC_SC_DLY_HI:`PRC_SC_DLY_LO];
                s_d.buck2_force_fixed_mode = s_q.sh[`PRC_SC_BUCK2_FORCE_FIXED_MODE];
                s_d.buck1_force_fixed_mode = s_q.sh[`PRC_SC_BUCK1_FORCE_FIXED_MODE];
              end
              `PRC_OFS_REG_EN: begin
                s_d.on.linreg2 = s_q.sh[`PRC_EN_LIN2];
                s_d.on.linreg1 = s_q.sh[`PRC_EN_LIN1];
                s_d.on.buck2 = s_q.sh[`PRC_EN_BK2];
                s_d.on.buck1 = s_q.sh[`PRC_EN_BK1];
              end
              `PRC_OFS_VCHG: begin
                s_d.buck2_target_select = s_q.sh[`PRC_VC_SEL2];
                s_d.buck2_ramp_go = s_q.sh[`PRC_VC_GO2];
                s_d.buck1_target_select = s_q.sh[`PRC_VC_SEL1];
                s_d.buck1_ramp_go = s_q.sh[`PRC_VC_GO1];
              end
              `PRC_OFS_B1_TGT_A: s_d.buck1_target_a = s_q.sh[`PRC_TGT_HI:0];
              default: s_d.ptr = s_q.ptr + 8'h01;
            endcase
          end
        end
        PRC_RDATA: begin
          if (s_q.bits == 4'h8) begin
            s_d.oe = 1'b0;
            s_d.st = PRC_RDATA_ACK;
          end else begin
            s_d.sh = {s_q.sh[6:0], 1'b0};
            s_d.oe = ~s_d.sh[7];
          end
        end
        PRC_RDATA_ACK: begin
          if (s_q.nack) begin
            s_d.st = PRC_IDLE;
          end else begin
            s_d.ptr = s_q.ptr + 8'h01;
            s_d.sh = read_reg(s_q, s_d.ptr);
            s_d.oe = ~s_d.sh[7];
            s_d.bits = 4'h0;
            s_d.st = PRC_RDATA;
          end
        end
        default: s_d.st = PRC_IDLE;
      endcase
    end
    // ==========================================================
    // status flags and buck1 ramp
    s_d.status = 8'h00;
    s_d.status[`PRC_ST_ALLBK] = valid_in.buck1 & valid_in.buck2;
    s_d.status[`PRC_ST_ALLLIN] = valid_in.linreg1 & valid_in.linreg2;
    s_d.status[`PRC_ST_LIN2] = valid_in.linreg2;
    s_d.status[`PRC_ST_LIN1] = valid_in.linreg1;
    s_d.status[`PRC_ST_BK2] = valid_in.buck2;
    s_d.status[`PRC_ST_BK1] = valid_in.buck1;
    if (!s_q.buck1_ramp_go) begin
      s_d.ramp_div = 32'h0; // hold present code
    end else if (s_q.ramp_div == 32'(RAMP_CYCLES - 1)) begin
      s_d.ramp_div = 32'h0;
      if (s_q.b1_code < b1_goal) begin
        s_d.b1_code = s_q.b1_code + 5'h01;
      end else if (s_q.b1_code > b1_goal) begin
        s_d.b1_code = s_q.b1_code - 5'h01;
      end
    end else begin
      s_d.ramp_div = s_q.ramp_div + 32'h1;
    end
    s_d.b1_mv = b1_code_mv(s_q.b1_code);
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      s_q <= '0;
      s_q.st <= PRC_IDLE;
      s_q.pins <= '1;
      s_q.power_on_delay_code <= `PRC_DLY_RESET;
      s_q.buck1_force_fixed_mode <= BUCK1_FORCE_FIXED_MODE_DEFAULT;
      s_q.buck2_force_fixed_mode <= BUCK2_FORCE_FIXED_MODE_DEFAULT;
      s_q.on <= `PRC_EN_RESET;
      s_q.buck1_target_a <= B1_TGT_DEFAULT;
      s_q.b1_code <= B1_TGT_DEFAULT;
    end else begin
      s_q <= s_d;
    end
  end

  prc_power_seq #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_seq (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .en_pin_in(en_pin_in),
    .delay_code_in(s_q.power_on_delay_code),
    .reg_on_in(s_q.on),
    .reg_drive_out(reg_drive_out)
  );

  assign sda_out = 1'b0;
  assign sda_oe_out = s_q.oe;
  assign buck1_force_fixed_mode_out = s_q.buck1_force_fixed_mode;
  assign buck2_force_fixed_mode_out = s_q.buck2_force_fixed_mode;
  assign buck2_target_select_out = s_q.buck2_target_select;
  assign buck2_ramp_go_out = s_q.buck2_ramp_go;
  assign buck1_voltage_code_out = s_q.b1_code;
  assign buck1_ext_ctrl_out = (s_q.b1_code == 5'h00);
  assign buck1_mv_out = s_q.b1_mv;

endmodule

// ### dv/prc_host_model.sv
// serial bus host model for the regulator control register bank
// assumes a pull-up on sda; pins change only at falling clock edges
module prc_host_model
  import prc_pkg::*;
#(
  parameter logic [6:0] ADDR = 7'h60
) (
  // clock and slave drive
  input wire logic clk_in,
  input wire logic sda_oe_in,
  // bus lines
  output prc_pins_s pins_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  // wired-and of both drivers with pull-up
  assign pins_out = '{scl: scl_q, sda: sda_q & ~sda_oe_in};

  // ==========================================================
  // bus phases, a third of a bit each
  task automatic st(input logic c, input logic d);
    scl_q = c;
    sda_q = d;
    repeat (4) @(negedge clk_in);
  endtask

  task automatic start;
    st(scl_q, 1'b1);
    st(1'b1, 1'b1);
    st(1'b1, 1'b0);
    st(1'b0, 1'b0);
  endtask

  task automatic stop;
    st(1'b0, 1'b0);
    st(1'b1, 1'b0);
    st(1'b1, 1'b1);
  endtask

  // eight bits msb first plus the acknowledge bit
  task automatic xfer(input logic [8:0] w, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      st(1'b0, w[i]);
      st(1'b1, w[i]);
      r[i] = pins_out.sda;
      st(1'b0, w[i]);
    end
  endtask

  task automatic wr(input logic [6:0] ad, input logic [7:0] a, input logic [7:0] d,
                    output logic ok);
    logic [8:0] r0, r1, r2;
    start;
    xfer({ad, 1'b0, 1'b1}, r0);
    xfer({a, 1'b1}, r1);
    xfer({d, 1'b1}, r2);
    stop;
    ok = !(r0[0] | r1[0] | r2[0]);
  endtask

  // pointer write, repeated start, one byte, nack
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [8:0] r;
    start;
    xfer({ADDR, 1'b0, 1'b1}, r);
    xfer({a, 1'b1}, r);
    start;
    xfer({ADDR, 1'b1, 1'b1}, r);
    // release sda for the data byte, then nack it
    xfer(9'h1FF, r);
    d = r[8:1];
    stop;
  endtask
endmodule

// ### dv/prc_regs_chk.sv
// assertions on the ports of the regulator control register bank
// assumes one clock domain and a synchronous active-high reset
module prc_regs_chk
  import prc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // serial bus
  input prc_pins_s pins_in,
  input logic sda_out,
  input logic sda_oe_out,
  // power
  input wire logic en_pin_in,
  input prc_regs4_s reg_drive_out,
  input logic buck1_force_fixed_mode_out,
  input logic buck2_force_fixed_mode_out,
  input logic buck2_target_select_out,
  input logic buck2_ramp_go_out,
  input logic [4:0] buck1_voltage_code_out,
  input logic buck1_ext_ctrl_out,
  input logic [11:0] buck1_mv_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  function automatic logic [11:0] mv_of(input logic [4:0] c);
    if (c == 5'h00) return 12'h000;
    if (c > 5'h19) return 12'h7D0;
    return 12'h320 + 12'h032 * (c - 5'h01);
  endfunction

  // ==========================================================
  // properties
  ext_ctrl_a: assert property (buck1_ext_ctrl_out == (buck1_voltage_code_out == 5'h00))
    else $error("ext control flag does not match code");
  mv_decode_a: assert property (!$past(srst_in) |->
    buck1_mv_out == mv_of($past(buck1_voltage_code_out)))
    else $error("millivolt output wrong for code");
  ramp_step_a: assert property ($changed(buck1_voltage_code_out) |->
    buck1_voltage_code_out == $past(buck1_voltage_code_out) + 5'h01 ||
    buck1_voltage_code_out == $past(buck1_voltage_code_out) - 5'h01)
    else $error("applied code jumped more than one step");
  sda_low_a: assert property (sda_out == 1'b0)
    else $error("sda data not low");
  oe_scl_low_a: assert property ($changed(sda_oe_out) |->
    !pins_in.scl && !$past(pins_in.scl))
    else $error("sda drive changed near scl high");
  rst_clear_a: assert property ($fell(srst_in) |->
    !sda_oe_out && reg_drive_out == '0)
    else $error("outputs not cleared by reset");
  en_low_a: assert property (!en_pin_in [*2] |-> reg_drive_out == '0)
    else $error("regulator driven without enable pin");
  min_delay_a: assert property ($rose(en_pin_in) |-> reg_drive_out == '0 [*6])
    else $error("regulator started before shortest delay");
  mode_write_a: assert property ($changed({buck1_force_fixed_mode_out,
    buck2_force_fixed_mode_out}) |-> !pins_in.scl && !$past(pins_in.scl))
    else $error("mode bit changed outside a write");
  buck2_write_a: assert property ($changed({buck2_target_select_out,
    buck2_ramp_go_out}) |-> !pins_in.scl && !$past(pins_in.scl))
    else $error("buck2 control changed outside a write");

  cover property ($rose(sda_oe_out));
  cover property ($rose(buck1_ext_ctrl_out));
  cover property ($rose(reg_drive_out.linreg2));
endmodule

bind prc_regulator_control_regs prc_regs_chk i_prc_regs_chk (
  .ref_clk_in(ref_clk_in), .srst_in(srst_in), .pins_in(pins_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .en_pin_in(en_pin_in), .reg_drive_out(reg_drive_out),
  .buck1_force_fixed_mode_out(buck1_force_fixed_mode_out),
  .buck2_force_fixed_mode_out(buck2_force_fixed_mode_out),
  .buck2_target_select_out(buck2_target_select_out), .buck2_ramp_go_out(buck2_ramp_go_out),
  .buck1_voltage_code_out(buck1_voltage_code_out), .buck1_ext_ctrl_out(buck1_ext_ctrl_out),
  .buck1_mv_out(buck1_mv_out));

// ### dv/tb_top.sv
// self-checking bench for the regulator control register bank
// assumes host model and checker are compiled before this file
module tb_top
  import prc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [6:0] DEV = 7'h60;
  // start delays in half-ms units: buck1, buck2, linreg1, linreg2
  localparam byte DLY [8][4] = '{'{2, 2, 2, 2}, '{2, 3, 4, 4}, '{3, 4, 6, 12},
    '{3, 4, 2, 2}, '{3, 4, 6, 12}, '{3, 3, 4, 4}, '{6, 4, 2, 3}, '{4, 6, 12, 22}};
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic en_pin_in = 1'b0;
  prc_regs4_s valid_in = '0;
  logic [4:0] tgt_b = 5'h00;
  prc_pins_s pins;
  prc_regs4_s drive;
  logic sda_out, sda_oe, fm1, fm2, sel2, go2, ext, ok;
  logic [4:0] code;
  logic [11:0] mv;
  int t [4];
  int num_errors = 0;
  int comparisons = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  prc_host_model #(.ADDR(DEV)) i_prc_host_model (.clk_in(ref_clk_in), .sda_oe_in(sda_oe),
    .pins_out(pins));
  prc_regulator_control_regs #(.DEV_ADDR(DEV), .UNIT_CYCLES(4), .RAMP_CYCLES(3))
    i_prc_regulator_control_regs (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .pins_in(pins),
    .sda_out(sda_out), .sda_oe_out(sda_oe), .en_pin_in(en_pin_in), .valid_in(valid_in),
    .buck1_target_b_in(tgt_b), .reg_drive_out(drive), .buck1_force_fixed_mode_out(fm1),
    .buck2_force_fixed_mode_out(fm2), .buck2_target_select_out(sel2),
    .buck2_ramp_go_out(go2), .buck1_voltage_code_out(code), .buck1_ext_ctrl_out(ext),
    .buck1_mv_out(mv));

  // ==========================================================
  // access and compare tasks
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic k;
    i_prc_host_model.wr(DEV, a, d, k);
    chk("ack", 12'h001, {11'h000, k});
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_prc_host_model.rd(a, d);
    chk($sformatf("reg %h", a), {4'h0, e}, {4'h0, d});
  endtask

  task automatic results;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk_in);
    num_errors++;
    results;
  end

  // ==========================================================
  // tests
  initial begin
    repeat (2) @(negedge ref_clk_in);
    srst_in = 1'b0;
    rchk(8'h07, 8'h28);
    rchk(8'h10, 8'h75);
    rchk(8'h20, 8'h00);
    rchk(8'h23, 8'h09);
    w(8'h07, 8'hFF);
    rchk(8'h07, 8'h7E);
    chk("mode", 12'h003, {10'h000, fm2, fm1});
    w(8'h07, 8'h00);
    rchk(8'h07, 8'h08);
    chk("mode", 12'h000, {10'h000, fm2, fm1});
    w(8'h30, 8'h5A);
    rchk(8'h30, 8'h00);
    i_prc_host_model.wr(7'h61, 8'h10, 8'h00, ok);
    chk("bad addr ack", 12'h000, {11'h000, ok});
    w(8'h11, 8'hFF);
    for (int v = 0; v < 16; v++) begin
      valid_in = prc_regs4_s'(v[3:0]);
      rchk(8'h11, {v[0] & v[1], v[2] & v[3], v[3], v[2], 1'b0, v[1], 1'b0, v[0]});
    end
    for (int k = 0; k < 8; k++) begin
      w(8'h07, {1'b0, k[2:0], 4'h0});
      t = '{default: 0};
      en_pin_in = 1'b1;
      for (int c = 1; c < 120; c++) begin
        @(negedge ref_clk_in);
        for (int i = 0; i < 4; i++) begin
          if (drive[i] && t[i] == 0) t[i] = c;
        end
      end
      for (int i = 0; i < 4; i++) begin
        ok = t[i] >= 4 * DLY[k][i] - 1 && t[i] <= 4 * DLY[k][i] + 3;
        chk($sformatf("delay %0d/%0d", k, i), 12'h001, {11'h000, ok});
      end
      en_pin_in = 1'b0;
      repeat (4) @(negedge ref_clk_in);
    end
    w(8'h10, 8'hAA);
    rchk(8'h10, 8'h20);
    en_pin_in = 1'b1;
    repeat (120) @(negedge ref_clk_in);
    chk("drive off", 12'h000, {8'h00, drive});
    en_pin_in = 1'b0;
    w(8'h10, 8'h55);
    rchk(8'h10, 8'h75);
    w(8'h23, 8'hEC);
    rchk(8'h23, 8'h0C);
    chk("hold", 12'h009, {7'h00, code});
    w(8'h20, 8'h01);
    repeat (40) @(negedge ref_clk_in);
    chk("code a", 12'h00C, {7'h00, code});
    chk("mv a", 12'h546, mv);
    tgt_b = 5'h1F;
    w(8'h20, 8'h03);
    repeat (100) @(negedge ref_clk_in);
    chk("code b", 12'h01F, {7'h00, code});
    chk("mv sat", 12'h7D0, mv);
    w(8'h23, 8'h00);
    w(8'h20, 8'h01);
    repeat (120) @(negedge ref_clk_in);
    chk("ext", 12'h001, {11'h000, ext});
    chk("mv ext", 12'h000, mv);
    w(8'h20, 8'h00);
    w(8'h23, 8'h05);
    repeat (30) @(negedge ref_clk_in);
    chk("hold 0", 12'h000, {7'h00, code});
    w(8'h20, 8'hFF);
    rchk(8'h20, 8'h33);
    chk("buck2 ctl", 12'h003, {10'h000, sel2, go2});
    results;
  end
endmodule
